// file: hdl/adrc_params.svh
// constants for the converter readout and power-down control block
`ifndef ADRC_PARAMS_SVH
`define ADRC_PARAMS_SVH

// =====================================================================
// timing
`define ADRC_CLK_PERIOD_NS 8
`define ADRC_OSC_START_US 1000
`define ADRC_CONV_PERIOD_US 8000
`define ADRC_SETTLE_US 24000
`define ADRC_GUARD_US 20
`define ADRC_OSC_START_CYC (((`ADRC_OSC_START_US * 1000) + `ADRC_CLK_PERIOD_NS - 1) / `ADRC_CLK_PERIOD_NS)
`define ADRC_CONV_PERIOD_CYC ((`ADRC_CONV_PERIOD_US * 1000) / `ADRC_CLK_PERIOD_NS)
`define ADRC_GUARD_CYC (((`ADRC_GUARD_US * 1000) + `ADRC_CLK_PERIOD_NS - 1) / `ADRC_CLK_PERIOD_NS)
`define ADRC_SETTLE_CONV (`ADRC_SETTLE_US / `ADRC_CONV_PERIOD_US)
`define ADRC_CNT_W 20

// =====================================================================
// serial word
`define ADRC_WORD_BITS 24
`define ADRC_CODE_BITS 16
`define ADRC_PATTERN 3'h5
`define ADRC_ZERO_BIT 1'h0
// identity code, the value is arbitrary
`define ADRC_IDENTITY 2'h3

// =====================================================================
// register map
`define ADRC_ADDR_W 12
`define ADRC_REG_SAMPLE 12'h000
`define ADRC_REG_STATUS 12'h004
`define ADRC_REG_LAST 12'h008
`define ADRC_SAMPLE_ERR_BIT 16
`define ADRC_SAMPLE_CODE_RST 16'h8000

`endif

// file: hdl/adrc_pkg.sv
// types for the converter readout and power-down control block
`include "adrc_params.svh"

package adrc_pkg;

  // =====================================================================
  // phase of the device, gray along power-down, start, settle, run
  typedef enum logic [1:0] {
    ADRC_PWRDN  = 2'h0,
    ADRC_START  = 2'h1,
    ADRC_SETTLE = 2'h3,
    ADRC_RUN    = 2'h2
  } adrc_phase_t;

  // =====================================================================
  // status byte, first field goes out first
  typedef struct packed {
    logic rdy_n;
    logic zero;
    logic err;
    logic identity_bit_high;
    logic identity_bit_low;
    logic check_pattern_bit2;
    logic check_pattern_bit1;
    logic check_pattern_bit0;
  } adrc_status_t;

  typedef struct packed {
    logic [`ADRC_CODE_BITS-1:0] code;
    adrc_status_t status;
  } adrc_word_t;

  // result as presented by the modulator stand-in
  typedef struct packed {
    logic err;
    logic [`ADRC_CODE_BITS-1:0] code;
  } adrc_sample_t;

  // =====================================================================
  // whole state of the control block except the two-stage reset synchronizer
  typedef struct packed {
    logic pd_s1;
    logic pd_s2;
    logic ck_s1;
    logic ck_s2;
    logic ck_s3;
    adrc_phase_t phase;
    logic [`ADRC_CNT_W-1:0] cnt;
    logic [1:0] conv_cnt;
    adrc_sample_t sample;
    adrc_word_t shift;
    adrc_word_t last;
    logic [4:0] bit_cnt;
    logic rdy;
    logic dout;
    logic dout_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } adrc_state_t;

endpackage

// file: hdl/adrc_ctrl.sv
// converter readout, conversion pacing and power-down/reset control
//
// Contract
// - one new conversion completes every 8 ms conversion period.
// - every finished conversion overwrites the data register, settling or not.
// - power-down low stops timing and conversions; data pin tristated.
// - power-down low clears control, settle and serial state; the sample and last word are kept.
// - after power-down release wait 1 ms oscillator start before sampling.
// - on leaving power-down drive data pin high until first valid result.
// - power-up performs a full reset automatically, sample and last word included.
// - results are offset binary, zero input is top bit only.
// - data pin driven low while a fresh result waits.
// - bits shift on the host serial clock, continuous or in bursts.
// - each read gives 24 bits: 16-bit result then status byte.
// - status order: ready, zero, error, two identity, three pattern bits.
// - status ready bit reads low when the word holds a conversion.
// - status error bit is one when input was out of range.
// - two status bits carry a fixed identity code.
// - three trailing status bits always read 101.
// - data pin returns high once the word has been read.
// - unread result: pin goes high shortly before the next update.
// - each conversion can be read only once.
// - new conversion resets shifter; host must finish reading before it.

`include "adrc_params.svh"

module adrc_ctrl #(
  parameter int unsigned P_OSC_START_CYC = `ADRC_OSC_START_CYC,
  parameter int unsigned P_CONV_PERIOD_CYC = `ADRC_CONV_PERIOD_CYC
) (
  // clock and power-up reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // pins towards the host
  input wire logic i_powerdown_reset_pin_n,
  input wire logic i_sclk,
  output logic o_dout,
  output logic o_dout_oe,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`ADRC_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);

  // =====================================================================
  // constants
  localparam logic [`ADRC_CNT_W-1:0] START_LAST = `ADRC_CNT_W'(P_OSC_START_CYC - 1);
  localparam logic [`ADRC_CNT_W-1:0] PERIOD_LAST = `ADRC_CNT_W'(P_CONV_PERIOD_CYC - 1);
  localparam logic [`ADRC_CNT_W-1:0] GUARD_START =
    `ADRC_CNT_W'(P_CONV_PERIOD_CYC - `ADRC_GUARD_CYC);
  localparam logic [1:0] SETTLE_LAST = 2'(`ADRC_SETTLE_CONV - 1);
  localparam logic [4:0] WORD_BITS = 5'(`ADRC_WORD_BITS);

  localparam adrc_pkg::adrc_state_t ST_RST = '{
    pd_s1: 1'h0,
    pd_s2: 1'h0,
    ck_s1: 1'h1,
    ck_s2: 1'h1,
    ck_s3: 1'h1,
    phase: adrc_pkg::ADRC_PWRDN,
    cnt: '0,
    conv_cnt: 2'h0,
    sample: '{err: 1'h0, code: `ADRC_SAMPLE_CODE_RST},
    shift: '0,
    last: '0,
    bit_cnt: 5'h0,
    rdy: 1'h0,
    dout: 1'h1,
    dout_oe: 1'h0,
    prdata: 32'h0,
    pready: 1'h0,
    pslverr: 1'h0
  };

  // =====================================================================
  // reset release, two stages so the release is synchronous
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_sync_r <= 2'h0;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], 1'h1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // =====================================================================
  // state
  adrc_pkg::adrc_state_t st_r;
  adrc_pkg::adrc_state_t st_nxt;
  adrc_pkg::adrc_word_t new_word;
  logic sclk_fall;
  logic sclk_rise;
  logic conv_done;
  logic apb_setup;
  logic apb_write;

  assign sclk_fall = st_r.ck_s3 & ~st_r.ck_s2;
  assign sclk_rise = ~st_r.ck_s3 & st_r.ck_s2;
  assign conv_done = (st_r.cnt == PERIOD_LAST);
  assign apb_setup = i_psel & ~i_penable;
  assign apb_write = i_psel & i_penable & st_r.pready & i_pwrite;

  // word built from the modulator result; code is already offset binary
  always_comb
  begin
    new_word.code = st_r.sample.code;
    new_word.status.rdy_n = 1'h0;
    new_word.status.zero = `ADRC_ZERO_BIT;
    new_word.status.err = st_r.sample.err;
    // identity value is arbitrary
    {new_word.status.identity_bit_high, new_word.status.identity_bit_low} =
      `ADRC_IDENTITY;
    {new_word.status.check_pattern_bit2, new_word.status.check_pattern_bit1,
     new_word.status.check_pattern_bit0} = `ADRC_PATTERN;
  end

  always_comb
  begin
    st_nxt = st_r;
    // pins pass two stages before anything looks at them
    st_nxt.pd_s1 = i_powerdown_reset_pin_n;
    st_nxt.pd_s2 = st_r.pd_s1;
    st_nxt.ck_s1 = i_sclk;
    st_nxt.ck_s2 = st_r.ck_s1;
    st_nxt.ck_s3 = st_r.ck_s2;

    // -------------------------------------------------------------------
    // apb: zero wait states, answer prepared in the setup cycle
    st_nxt.pready = apb_setup;
    st_nxt.pslverr = 1'h0;
    st_nxt.prdata = 32'h0;
    if (apb_setup)
    begin
      unique case (i_paddr)
        `ADRC_REG_SAMPLE:
        begin
          st_nxt.prdata = {15'h0, st_r.sample};
        end
        `ADRC_REG_STATUS:
        begin
          st_nxt.prdata = {22'h0, st_r.bit_cnt, st_r.conv_cnt, st_r.rdy,
                           st_r.phase};
        end
        `ADRC_REG_LAST:
        begin
          st_nxt.prdata = {8'h0, st_r.last};
        end
        default:
        begin
          st_nxt.pslverr = 1'h1;
        end
      endcase
    end
    if (apb_write && i_paddr == `ADRC_REG_SAMPLE)
    begin
      st_nxt.sample = i_pwdata[`ADRC_SAMPLE_ERR_BIT:0];
    end

    // -------------------------------------------------------------------
    // converter sequence
    if (!st_r.pd_s2)
    begin
      // powered down: clock stopped, sequence and shifter cleared, sample and last kept, pin released
      st_nxt.phase = adrc_pkg::ADRC_PWRDN;
      st_nxt.cnt = '0;
      st_nxt.conv_cnt = 2'h0;
      st_nxt.shift = '0;
      st_nxt.bit_cnt = 5'h0;
      st_nxt.rdy = 1'h0;
      st_nxt.dout = 1'h1;
      st_nxt.dout_oe = 1'h0;
    end
    else
    begin
      unique case (st_r.phase)
        adrc_pkg::ADRC_PWRDN:
        begin
          // leaving power-down: pin driven high straight away
          st_nxt.phase = adrc_pkg::ADRC_START;
          st_nxt.cnt = '0;
          st_nxt.dout = 1'h1;
          st_nxt.dout_oe = 1'h1;
        end
        adrc_pkg::ADRC_START:
        begin
          // oscillator start-up, the modulator does not sample yet
          st_nxt.cnt = st_r.cnt + 1'h1;
          if (st_r.cnt == START_LAST)
          begin
            st_nxt.phase = adrc_pkg::ADRC_SETTLE;
            st_nxt.cnt = '0;
          end
        end
        adrc_pkg::ADRC_SETTLE:
        begin
          st_nxt.cnt = st_r.cnt + 1'h1;
          if (conv_done)
          begin
            // filter settling: register updated, signalled only from the third result
            st_nxt.cnt = '0;
            st_nxt.last = new_word;
            st_nxt.shift = new_word;
            st_nxt.conv_cnt = st_r.conv_cnt + 1'h1;
            if (st_r.conv_cnt == SETTLE_LAST)
            begin
              st_nxt.phase = adrc_pkg::ADRC_RUN;
              st_nxt.rdy = 1'h1;
              st_nxt.dout = 1'h0;
              st_nxt.bit_cnt = 5'h0;
            end
          end
        end
        adrc_pkg::ADRC_RUN:
        begin
          st_nxt.cnt = st_r.cnt + 1'h1;
          if (st_r.rdy)
          begin
            if (sclk_fall && st_r.bit_cnt != WORD_BITS)
            begin
              // msb first, changed on the falling edge
              st_nxt.dout = st_r.shift[`ADRC_WORD_BITS-1];
              st_nxt.shift = {st_r.shift[`ADRC_WORD_BITS-2:0], 1'h0};
              st_nxt.bit_cnt = st_r.bit_cnt + 1'h1;
            end
            else if (sclk_rise && st_r.bit_cnt == WORD_BITS)
            begin
              // last bit sampled: word consumed, no second read
              st_nxt.rdy = 1'h0;
              st_nxt.dout = 1'h1;
            end
            else if (st_r.bit_cnt == 5'h0 && st_r.cnt >= GUARD_START)
            begin
              // unread result withdrawn ahead of the register update
              st_nxt.rdy = 1'h0;
              st_nxt.dout = 1'h1;
            end
          end
          if (conv_done)
          begin
            // a read still in progress is cut off here
            st_nxt.cnt = '0;
            st_nxt.last = new_word;
            st_nxt.shift = new_word;
            st_nxt.bit_cnt = 5'h0;
            st_nxt.rdy = 1'h1;
            st_nxt.dout = 1'h0;
          end
        end
      endcase
    end
  end

  // power-up reset reaches every flip-flop; pin reset clears only the sequence and serial state
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= ST_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // =====================================================================
  // outputs, all straight from the state register
  assign o_dout = st_r.dout;
  assign o_dout_oe = st_r.dout_oe;
  assign o_prdata = st_r.prdata;
  assign o_pready = st_r.pready;
  assign o_pslverr = st_r.pslverr;

endmodule

// file: verif/adrc_ctrl_monitor.sv
// port checker for the converter readout block
`include "adrc_params.svh"
module adrc_ctrl_monitor #(
  parameter int unsigned P_OSC_START_CYC = `ADRC_OSC_START_CYC,
  parameter int unsigned P_CONV_PERIOD_CYC = `ADRC_CONV_PERIOD_CYC
) (
  // clock, reset and pins
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_powerdown_reset_pin_n,
  input wire logic o_dout,
  input wire logic o_dout_oe,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [`ADRC_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // cycle counts since the pin was driven, and since it was last driven high
  logic [31:0] up_cnt;
  logic [31:0] hi_cnt;
  logic run_seen;
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      up_cnt <= '0;
      hi_cnt <= '0;
      run_seen <= 1'b0;
    end
    else
    begin
      up_cnt <= o_dout_oe ? up_cnt + 1 : '0;
      hi_cnt <= (o_dout_oe && o_dout) ? hi_cnt + 1 : '0;
      run_seen <= o_dout_oe && (run_seen || !o_dout);
    end
  end
  // ==========
  // assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  chk_pd_tristate: assert property (!i_powerdown_reset_pin_n [*5] |-> !o_dout_oe)
    else $error("data pin driven in power-down");
  chk_power_up: assert property ($rose(i_rst_n) |-> !o_dout_oe [*3])
    else $error("data pin driven right after power-up");
  chk_start_high: assert property ($rose(o_dout_oe) |-> o_dout [*8])
    else $error("data pin not high on leaving power-down");
  chk_first_data: assert property (o_dout_oe && !o_dout && !run_seen |->
    up_cnt inside {[P_OSC_START_CYC + 3 * P_CONV_PERIOD_CYC - 8 :
    P_OSC_START_CYC + 3 * P_CONV_PERIOD_CYC + 8]}) else $error("first result at wrong time");
  chk_run_rate: assert property (run_seen && o_dout_oe |-> hi_cnt <= P_CONV_PERIOD_CYC)
    else $error("no result within one period");
  chk_apb_answer: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  chk_apb_cause: assert property (o_pready |-> $past(i_psel && !i_penable))
    else $error("ready without setup");
  chk_apb_refuse: assert property (o_pready && i_paddr > 12'h008 |-> o_pslverr)
    else $error("unmapped access not refused");
  chk_apb_quiet: assert property (!o_pready |-> o_prdata == 32'h0 && !o_pslverr)
    else $error("read bus not quiet");
  cover property (run_seen && $fell(o_dout));
  cover property ($fell(o_dout_oe));
  cover property (o_pslverr);
endmodule
bind adrc_ctrl adrc_ctrl_monitor #(.P_OSC_START_CYC(P_OSC_START_CYC),
  .P_CONV_PERIOD_CYC(P_CONV_PERIOD_CYC)) u_mon (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_powerdown_reset_pin_n(i_powerdown_reset_pin_n), .o_dout(o_dout),
  .o_dout_oe(o_dout_oe), .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));

// file: verif/adrc_host.sv
// host model: serial clock and power-down pin
module adrc_host (
  // data line from the device
  input wire logic i_dout,
  input wire logic i_dout_oe,
  // pins the host drives
  output logic o_sclk,
  output logic o_pd_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic b = 1'b0;
  initial
  begin
    o_sclk = 1'b1;
    o_pd_n = 1'b0;
  end
  // offset keeps pin edges clear of the system clock edge
  task automatic set_pd(input logic v);
    #5 o_pd_n = v;
  endtask
  // msb first, sampled on rising edge; a released line reads as alternating bits
  task automatic clk_bits(input int nb, inout logic [23:0] w);
    #3;
    repeat (nb)
    begin
      #32 o_sclk = 1'b0;
      #32 o_sclk = 1'b1;
      b = i_dout_oe ? i_dout : ~b;
      w = {w[22:0], b};
    end
  endtask
endmodule

// file: verif/tb_adrc_ctrl.sv
// bench for the converter readout block
`include "adrc_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_adrc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CONV = 3000;
  localparam logic [16:0] CORNER [4] = '{17'h1_0000, 17'h0_8000, 17'h0_ffff, 17'h1_7fff};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, dout, dout_oe, sclk, pd_n, er;
  logic [23:0] w;
  logic [16:0] smp;
  int mismatches = 0;
  int checked = 0;
  int n;
  always #4 clk = ~clk;
  adrc_ctrl #(.P_OSC_START_CYC(20), .P_CONV_PERIOD_CYC(CONV)) u_dut (.i_sys_clk(clk),
    .i_rst_n(rst_n), .i_powerdown_reset_pin_n(pd_n), .i_sclk(sclk), .o_dout(dout),
    .o_dout_oe(dout_oe), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr));
  adrc_host u_host (.i_dout(dout), .i_dout_oe(dout_oe), .o_sclk(sclk), .o_pd_n(pd_n));
  function automatic logic [23:0] exp_word(logic [16:0] s);
    return {s[15:0], 2'b00, s[16], `ADRC_IDENTITY, `ADRC_PATTERN};
  endfunction
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [16:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {15'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK("apb wait", 1'b1, 1'(n < 16))
    if (n >= 16) end_sim();
  endtask
  task automatic wait_rdy();
    for (n = 0; !(dout_oe === 1'b1 && dout === 1'b0) && n < 4 * CONV; n++)
      @(posedge clk);
    `CHK("ready wait", 1'b1, 1'(n < 4 * CONV))
    if (n >= 4 * CONV) end_sim();
  endtask
  task automatic read_chk(input int first);
    w = '0;
    u_host.clk_bits(first, w);
    repeat (20) @(posedge clk);
    u_host.clk_bits(24 - first, w);
    `CHK("word", exp_word(smp), w)
    `CHK("pattern", 3'b101, w[2:0])
  endtask
  initial
  begin
    void'($urandom(44));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // internal reset is still held for two edges after the release
    repeat (2) @(posedge clk);
    apb(1'b0, `ADRC_REG_SAMPLE, '0);
    `CHK("sample", 32'h8000, rd)
    apb(1'b1, `ADRC_REG_STATUS, '1);
    apb(1'b0, `ADRC_REG_STATUS, '0);
    `CHK("status", 32'h0, rd)
    apb(1'b0, 12'h00c, '0);
    `CHK("unmapped", 1'b1, er)
    $display("test reset done");
    smp = CORNER[0];
    apb(1'b1, `ADRC_REG_SAMPLE, smp);
    u_host.set_pd(1'b1);
    repeat (6) @(posedge clk);
    `CHK("start", 2'b11, {dout_oe, dout})
    for (int i = 0; i < 9; i++)
    begin
      wait_rdy();
      read_chk(i == 1 ? 10 : 0);
      repeat (6) @(posedge clk);
      `CHK("done", 1'b1, dout)
      u_host.clk_bits(4, w);
      `CHK("reread", 4'hf, w[3:0])
      apb(1'b0, `ADRC_REG_LAST, '0);
      `CHK("last", exp_word(smp), rd[23:0])
      smp = (i < 3) ? CORNER[i + 1] : 17'($urandom);
      apb(1'b1, `ADRC_REG_SAMPLE, smp);
    end
    $display("test readout done");
    // a read left a third done must be cut off by the next conversion
    wait_rdy();
    u_host.clk_bits(8, w);
    smp = 17'($urandom);
    apb(1'b1, `ADRC_REG_SAMPLE, smp);
    apb(1'b0, `ADRC_REG_STATUS, '0);
    `CHK("partial", 5'h08, rd[9:5])
    for (int k = 0; rd[9:5] != 5'h00 && k < CONV; k++)
      apb(1'b0, `ADRC_REG_STATUS, '0);
    `CHK("cut", 5'h00, rd[9:5])
    if (rd[9:5] != 5'h00) end_sim();
    `CHK("reload", 1'b0, dout)
    read_chk(0);
    $display("test cut-off done");
    wait_rdy();
    smp = 17'($urandom);
    apb(1'b1, `ADRC_REG_SAMPLE, smp);
    for (n = 0; dout === 1'b0 && n < CONV; n++)
      @(posedge clk);
    `CHK("guard", 1'b1, 1'(n + 20 > CONV - `ADRC_GUARD_CYC && n < CONV - `ADRC_GUARD_CYC + 8))
    wait_rdy();
    read_chk(0);
    $display("test unread done");
    u_host.set_pd(1'b0);
    repeat (16) @(posedge clk);
    `CHK("off", 1'b0, dout_oe)
    apb(1'b0, `ADRC_REG_STATUS, '0);
    `CHK("cleared", 32'h0, rd)
    u_host.set_pd(1'b1);
    repeat (6) @(posedge clk);
    `CHK("restart", 2'b11, {dout_oe, dout})
    wait_rdy();
    read_chk(0);
    $display("test power-down done");
    end_sim();
  end
endmodule
